// [gmr_map.svh]
// Constants of the gripper register slave: addresses, codes, fields,
// reset values and timing counts.
// Assumes inclusion by bare name from the package and the design.
`ifndef GMR_MAP_SVH
`define GMR_MAP_SVH

// ==========================================================
// Register addresses
`define GMR_REG_ACTION 16'h03E8
`define GMR_REG_POSREQ 16'h03E9
`define GMR_REG_SPDFRC 16'h03EA
`define GMR_REG_STATUS 16'h07D0
`define GMR_NUM_WREGS 3

// ==========================================================
// Frame codes and identity
`define GMR_SLAVE_ID 8'h09
`define GMR_FC_READ 8'h03
`define GMR_FC_WRITE 8'h10
`define GMR_RD_FRAME_LEN 5'h08
`define GMR_WR_FIXED_LEN 5'h09
`define GMR_WR_RESP_LEN 4'h6
`define GMR_RD_RESP_HDR 4'h3

// ==========================================================
// Check value
`define GMR_CRC_INIT 16'hFFFF
`define GMR_CRC_POLY 16'hA001
`define GMR_CRC_RESIDUE 16'h0000

// ==========================================================
// Field positions inside the action and status words
`define GMR_ACT_BIT 8
`define GMR_GTO_BIT 11
`define GMR_STA_IDLE 2'h0
`define GMR_STA_PROG 2'h1
`define GMR_STA_DONE 2'h3
`define GMR_REG_RESET 16'h0000

// ==========================================================
// Buffer sizes
`define GMR_RX_DEPTH 16
`define GMR_TX_DEPTH 9

// ==========================================================
// Timing
`define GMR_CLK_PERIOD_NS 5
`define GMR_ACT_TIME_NS 10000
`define GMR_ACT_CYCLES (`GMR_ACT_TIME_NS / `GMR_CLK_PERIOD_NS)

`endif

// [gmr_pkg.sv]
// Types shared by the gripper register slave.
// Assumes gmr_map.svh is on the include path.
`include "gmr_map.svh"

package gmr_pkg;

  // ==========================================================
  // Frame engine phases
  typedef enum logic [1:0] {
    GMR_S_RX,
    GMR_S_DEC,
    GMR_S_TX
  } gmr_fsm_t;

  // ==========================================================
  // Command words handed to the motion logic
  typedef struct packed {
    logic [15:0] action_request_options; // Action request and options
    logic [15:0] options2_position_request; // Options 2 and position
    logic [15:0] speed_force_request; // Speed and force
  } gmr_cmd_t;

  // ==========================================================
  // Whole state of the slave
  typedef struct packed {
    gmr_fsm_t fsm; // Frame engine phase
    logic [`GMR_RX_DEPTH-1:0][7:0] rx_buf; // Received frame bytes
    logic [4:0] rx_len; // Bytes received
    logic [15:0] rx_crc; // Running check over received bytes
    logic rx_ovf; // Frame too long
    logic [`GMR_TX_DEPTH-1:0][7:0] tx_buf; // Response body
    logic [3:0] tx_len; // Body length
    logic [3:0] tx_idx; // Byte being sent
    logic [15:0] tx_crc; // Running check over sent bytes
    logic [7:0] tx_data; // Byte on the transmit port
    logic tx_valid; // Transmit byte offered
    logic [`GMR_NUM_WREGS-1:0][15:0] regs; // Writable registers
    logic [1:0] sta; // Activation state field
    logic [11:0] act_cnt; // Activation timer
  } gmr_st_t;

endpackage : gmr_pkg

// [gmr_crc_byte.sv]
// One byte step of the frame check value (reflected, poly A001).
// Assumes the caller holds the running value between bytes.
`timescale 1ns/1ps
`include "gmr_map.svh"

module gmr_crc_byte (
  input wire logic [15:0] crc_in, // Running value before the byte
  input wire logic [7:0] data, // Byte to fold in
  output logic [15:0] crc_out // Running value after the byte
);

  // ==========================================================
  // Eight shift steps, low bit first
  always_comb
  begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      if (c[0])
        c = (c >> 1) ^ `GMR_CRC_POLY;
      else
        c = c >> 1;
    end
    crc_out = c;
  end

endmodule // gmr_crc_byte

// [gmr_modbus_slave.sv]
// Frame-level register slave of a gripper: takes request bytes,
// checks and decodes read and write frames, keeps the command
// registers and the activation status, and sends the answer.
// Assumes a byte receiver and sender on the same clock; frame end
// comes from line silence, at least one cycle after the last byte.
`timescale 1ns/1ps
`include "gmr_map.svh"

module gmr_modbus_slave (
  input wire logic CLK, // 200 MHz clock
  input wire logic RST, // Asynchronous reset, active high
  input wire logic RX_VALID, // Received byte strobe
  input wire logic [7:0] RX_DATA, // Received byte
  input wire logic RX_FRAME_END, // Line silence closes the frame
  input wire logic TX_READY, // Sender takes the offered byte
  output logic [7:0] TX_DATA, // Byte to send
  output logic TX_VALID, // Byte offered to the sender
  output gmr_pkg::gmr_cmd_t GRIP_CMD, // Command words to motion logic
  output logic [1:0] ACT_STATE // Activation state field
);

  // ==========================================================
  // Declarations
  localparam int ACT_CYC = `GMR_ACT_CYCLES; // Activation length

  gmr_pkg::gmr_st_t q; // Registered state
  gmr_pkg::gmr_st_t d; // Next state
  logic [15:0] rx_crc_nx; // Check after the incoming byte
  logic [15:0] tx_crc_nx; // Check after the outgoing byte
  logic [7:0] tx_byte; // Byte due for sending
  logic [7:0] fc; // Function code of the frame
  logic [15:0] addr; // First register address
  logic [15:0] cnt; // Register count
  logic [7:0] bc; // Byte count of a write
  logic [16:0] wr_end; // One past the last written address
  logic crc_ok; // Frame check value good
  logic id_ok; // Frame is addressed to us
  logic rd_ok; // Well-formed read
  logic wr_ok; // Well-formed write inside the map
  logic [15:0] status; // Status word as read

  // ==========================================================
  // Check value steps for both directions
  gmr_crc_byte u_rx_crc (
    .crc_in(q.rx_crc),
    .data(RX_DATA),
    .crc_out(rx_crc_nx)
  );
  gmr_crc_byte u_tx_crc (
    .crc_in(q.tx_crc),
    .data(tx_byte),
    .crc_out(tx_crc_nx)
  );

  // ==========================================================
  // Frame fields and checks
  always_comb
  begin
    fc = q.rx_buf[1];
    addr = {q.rx_buf[2], q.rx_buf[3]};
    cnt = {q.rx_buf[4], q.rx_buf[5]};
    bc = q.rx_buf[6];
    // Check over the whole frame, its own value included, leaves zero
    crc_ok = (q.rx_crc == `GMR_CRC_RESIDUE);
    id_ok = (q.rx_buf[0] == `GMR_SLAVE_ID);
    // Reads of one to three words; unmapped words read as zero
    rd_ok = (fc == `GMR_FC_READ) && (q.rx_len == `GMR_RD_FRAME_LEN)
      && (cnt != 16'h0000) && (cnt <= 16'h0003);
    wr_end = {1'b0, addr} + {1'b0, cnt};
    // Field order, byte count and length must all agree
    wr_ok = (fc == `GMR_FC_WRITE) && (cnt != 16'h0000)
      && (cnt <= 16'h0003) && (bc == {cnt[6:0], 1'b0})
      && (q.rx_len == 5'(`GMR_WR_FIXED_LEN + {cnt[3:0], 1'b0}))
      && (addr >= `GMR_REG_ACTION)
      && (wr_end <= 17'({1'b0, `GMR_REG_SPDFRC} + 17'h00001));
  end

  // ==========================================================
  // Status word: echo bits, activation state, low byte zero
  assign status = {2'b00, q.sta, q.regs[0][`GMR_GTO_BIT], 2'b00,
    q.regs[0][`GMR_ACT_BIT], 8'h00};
  // Word seen by a read at a given address
  function automatic logic [15:0] rd_word(input logic [15:0] a);
    case (a)
      `GMR_REG_ACTION: rd_word = q.regs[0];
      `GMR_REG_POSREQ: rd_word = q.regs[1];
      `GMR_REG_SPDFRC: rd_word = q.regs[2];
      `GMR_REG_STATUS: rd_word = status;
      default: rd_word = 16'h0000;
    endcase
  endfunction

  // ==========================================================
  // Byte due on the line: body, then check low, then check high
  assign tx_byte = (q.tx_idx < q.tx_len) ? q.tx_buf[q.tx_idx]
    : (q.tx_idx == q.tx_len) ? q.tx_crc[7:0] : q.tx_crc[15:8];

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [1:0] off;
    off = 2'(addr - `GMR_REG_ACTION);
    d = q;
    // Activation timer runs while the state field says in progress
    if (q.sta == `GMR_STA_PROG)
    begin
      if (q.act_cnt == 12'(ACT_CYC - 1))
        d.sta = `GMR_STA_DONE;
      else
        d.act_cnt = q.act_cnt + 12'h001;
    end
    case (q.fsm)
      gmr_pkg::GMR_S_RX:
      begin
        // Collect bytes; too many marks the frame for discard
        if (RX_VALID)
        begin
          if (q.rx_len == 5'(`GMR_RX_DEPTH))
            d.rx_ovf = 1'b1;
          else
          begin
            d.rx_buf[q.rx_len[3:0]] = RX_DATA;
            d.rx_len = q.rx_len + 5'h01;
            d.rx_crc = rx_crc_nx;
          end
        end
        if (RX_FRAME_END)
        begin
          if (!q.rx_ovf && (q.rx_len != 5'h00))
            d.fsm = gmr_pkg::GMR_S_DEC;
          else
          begin
            d.rx_len = 5'h00;
            d.rx_crc = `GMR_CRC_INIT;
            d.rx_ovf = 1'b0;
          end
        end
      end
      gmr_pkg::GMR_S_DEC:
      begin
        // Unless answered below, the frame is dropped silently
        d.fsm = gmr_pkg::GMR_S_RX;
        d.rx_len = 5'h00;
        d.rx_crc = `GMR_CRC_INIT;
        d.rx_ovf = 1'b0;
        d.tx_idx = 4'h0;
        d.tx_crc = `GMR_CRC_INIT;
        if (crc_ok && id_ok && rd_ok)
        begin
          // Read answer: id, code, byte count, words high byte first
          d.tx_buf[0] = q.rx_buf[0];
          d.tx_buf[1] = fc;
          d.tx_buf[2] = {cnt[6:0], 1'b0};
          for (int i = 0; i < 3; i++)
          begin
            d.tx_buf[3 + 2 * i] = 8'(rd_word(addr + 16'(i)) >> 8);
            d.tx_buf[4 + 2 * i] = 8'(rd_word(addr + 16'(i)));
          end
          d.tx_len = 4'(`GMR_RD_RESP_HDR + {cnt[2:0], 1'b0});
          d.fsm = gmr_pkg::GMR_S_TX;
        end
        else if (crc_ok && id_ok && wr_ok)
        begin
          // Store words in address order
          for (int i = 0; i < 3; i++)
          begin
            if (16'(i) < cnt)
              d.regs[2'(off + 2'(i))] =
                {q.rx_buf[7 + 2 * i], q.rx_buf[8 + 2 * i]};
          end
          // Activation restarts only on a clear-then-set of the bit
          if (!d.regs[0][`GMR_ACT_BIT])
          begin
            d.sta = `GMR_STA_IDLE;
            d.act_cnt = 12'h000;
          end
          else if (!q.regs[0][`GMR_ACT_BIT])
          begin
            d.sta = `GMR_STA_PROG;
            d.act_cnt = 12'h000;
          end
          // Write answer echoes the first six bytes, no data
          for (int i = 0; i < 6; i++)
            d.tx_buf[i] = q.rx_buf[i];
          d.tx_len = `GMR_WR_RESP_LEN;
          d.fsm = gmr_pkg::GMR_S_TX;
        end
      end
      gmr_pkg::GMR_S_TX:
      begin
        // Offer one byte, hold it until taken; incoming bytes ignored
        if (!q.tx_valid)
        begin
          d.tx_valid = 1'b1;
          d.tx_data = tx_byte;
          if (q.tx_idx < q.tx_len)
            d.tx_crc = tx_crc_nx;
        end
        else if (TX_READY)
        begin
          d.tx_valid = 1'b0;
          d.tx_idx = q.tx_idx + 4'h1;
          if (q.tx_idx == q.tx_len + 4'h1)
            d.fsm = gmr_pkg::GMR_S_RX;
        end
      end
      default:
        d.fsm = gmr_pkg::GMR_S_RX;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      q <= '0;
      q.rx_crc <= `GMR_CRC_INIT;
      q.regs <= {`GMR_NUM_WREGS{`GMR_REG_RESET}};
    end
    else
      q <= d;
  end

  // ==========================================================
  // Outputs, all taken from the state register
  assign TX_DATA = q.tx_data;
  assign TX_VALID = q.tx_valid;
  assign GRIP_CMD.action_request_options = q.regs[0];
  assign GRIP_CMD.options2_position_request = q.regs[1];
  assign GRIP_CMD.speed_force_request = q.regs[2];
  assign ACT_STATE = q.sta;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // Bad or foreign frames never reach the sender
  property p_discard;
    q.fsm == gmr_pkg::GMR_S_DEC && !(crc_ok && id_ok)
      |=> q.fsm == gmr_pkg::GMR_S_RX ##1 !q.tx_valid;
  endproperty
  a_discard: assert property (p_discard)
    else $error("answer to a discarded frame");
  // Write answer is six bytes plus check value
  property p_wr_len;
    q.fsm == gmr_pkg::GMR_S_TX && q.tx_buf[1] == `GMR_FC_WRITE
      |-> q.tx_len == `GMR_WR_RESP_LEN;
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write answer length wrong");
  // Read answer byte count is even and sets the length
  property p_rd_len;
    q.fsm == gmr_pkg::GMR_S_TX && q.tx_buf[1] == `GMR_FC_READ
      |-> !q.tx_buf[2][0] && q.tx_len == 4'(q.tx_buf[2] + 8'h03);
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read answer byte count wrong");
  // In progress status reads 0x11 (go bit masked)
  property p_prog;
    q.sta == `GMR_STA_PROG |-> (status & 16'hF7FF) == 16'h1100;
  endproperty
  a_prog: assert property (p_prog)
    else $error("status not 0x11 in progress");
  // Finished status reads 0x31 (go bit masked)
  property p_done;
    q.sta == `GMR_STA_DONE |-> (status & 16'hF7FF) == 16'h3100;
  endproperty
  a_done: assert property (p_done)
    else $error("status not 0x31 when finished");
  // Activation completes exactly when the timer expires
  property p_act_time;
    q.sta == `GMR_STA_PROG && q.act_cnt == 12'(ACT_CYC - 1)
      && q.fsm != gmr_pkg::GMR_S_DEC
      |=> q.sta == `GMR_STA_DONE;
  endproperty
  a_act_time: assert property (p_act_time)
    else $error("activation did not finish on time");
  // Byte count mismatch leaves the registers alone
  property p_bc;
    q.fsm == gmr_pkg::GMR_S_DEC && fc == `GMR_FC_WRITE
      && bc != {cnt[6:0], 1'b0}
      |=> $stable(q.regs);
  endproperty
  a_bc: assert property (p_bc)
    else $error("write taken with bad byte count");
  // An offered byte stands until taken
  property p_tx_hold;
    q.tx_valid && !TX_READY |=> q.tx_valid && $stable(q.tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("offered byte dropped or changed");
  // Check value low byte follows the body
  property p_crc_lo;
    q.fsm == gmr_pkg::GMR_S_TX && !q.tx_valid && q.tx_idx == q.tx_len
      |=> q.tx_data == $past(q.tx_crc[7:0]);
  endproperty
  a_crc_lo: assert property (p_crc_lo)
    else $error("check value low byte wrong");
  // First data word of a write to the action address lands in the action register
  property p_reg0;
    q.fsm == gmr_pkg::GMR_S_DEC && crc_ok && id_ok && wr_ok
      && addr == `GMR_REG_ACTION
      |=> q.regs[0] == {$past(q.rx_buf[7]), $past(q.rx_buf[8])};
  endproperty
  a_reg0: assert property (p_reg0)
    else $error("action register not written");

  // Main scenarios
  c_write: cover property (q.fsm == gmr_pkg::GMR_S_TX
    && q.tx_buf[1] == `GMR_FC_WRITE);
  c_read: cover property (q.fsm == gmr_pkg::GMR_S_TX
    && q.tx_buf[1] == `GMR_FC_READ);
  c_done: cover property (q.sta == `GMR_STA_PROG
    ##1 q.sta == `GMR_STA_DONE);
  c_drop: cover property (q.fsm == gmr_pkg::GMR_S_DEC && !crc_ok);

endmodule // gmr_modbus_slave

// [gmr_master_model.sv]
// Behavioural robot controller on the byte side of the gripper slave.
// Assumes one shared clock; the bench fills out_q and calls send().
`timescale 1ns/1ps

module gmr_master_model #(
  parameter int GAP_CYCLES = 20 // Idle cycles before each request
) (
  input wire logic clk, // Shared clock
  input wire logic rst, // Reset, active high
  output logic rx_valid, // Request byte strobe
  output logic [7:0] rx_data, // Request byte
  output logic rx_frame_end, // Line silence after a request
  output logic tx_ready, // Takes answer bytes
  input wire logic [7:0] tx_data, // Answer byte
  input wire logic tx_valid // Answer byte offered
);
  // ==========================================================
  // State of the model
  logic [7:0] out_q [$]; // Whole request, check value included
  logic [7:0] got [$]; // Answer bytes taken so far
  int stall = 0; // Refused cycles between two takes
  int cyc = 0; // Free counter for the ready pattern

  // ==========================================================
  // Idle levels at time zero
  initial
  begin
    rx_valid = 1'h0;
    rx_data = 8'hA5;
    rx_frame_end = 1'h0;
  end

  // ==========================================================
  // Ready pattern; a slow sender exercises the hold of each byte
  initial
  begin
    tx_ready = 1'h0;
    forever
    begin
      @(posedge clk);
      #1;
      cyc++;
      tx_ready = (cyc % (stall + 1)) == 0;
    end
  end

  // Collect each byte at the edge where it is taken
  always @(posedge clk)
    if (!rst && tx_valid && tx_ready)
      got.push_back(tx_data);

  // ==========================================================
  // Send one frame back to back, then close it by silence
  task automatic send();
    repeat (GAP_CYCLES) @(posedge clk); // Spacing between commands
    foreach (out_q[i])
    begin
      @(posedge clk);
      #1;
      rx_valid = 1'h1;
      rx_data = out_q[i]; // Bytes in frame order
    end
    @(posedge clk);
    #1;
    rx_valid = 1'h0;
    // Released line shows no stale byte
    rx_data = ~rx_data;
    @(posedge clk);
    #1;
    rx_frame_end = 1'h1;
    @(posedge clk);
    #1;
    rx_frame_end = 1'h0;
  endtask
endmodule // gmr_master_model

// [gmr_modbus_slave_tb_top.sv]
// Self-checking bench of the gripper register slave: table of frames.
// Assumes gmr_map.svh, gmr_pkg and the master model are compiled first.
`timescale 1ns/1ps
`include "gmr_map.svh"

module gmr_modbus_slave_tb_top;
  // ==========================================================
  // Signals and table of frames
  typedef struct {
    logic [127:0] req; // Request without check value
    int rn; // Request length in bytes
    logic [79:0] rsp; // Answer without check value
    int sn; // Answer length, 0 when silence is due
    logic bad; // Corrupt the check value
    logic [47:0] cmd; // Command words afterwards
    logic [1:0] st; // Activation state afterwards
  } gmr_row_t;
  logic clk; // 200 MHz clock
  logic rst; // Reset, active high
  logic rx_valid; // Request byte strobe
  logic [7:0] rx_data; // Request byte
  logic rx_frame_end; // Frame closed
  logic tx_ready; // Answer byte taken
  logic [7:0] tx_data; // Answer byte
  logic tx_valid; // Answer byte offered
  gmr_pkg::gmr_cmd_t grip_cmd; // Command words
  logic [1:0] act_state; // Activation state
  int mismatches; // Failed comparisons
  int n_checks; // All comparisons
  gmr_row_t rows [17]; // Frames in run order

  gmr_modbus_slave gmr_modbus_slave_i (
    .CLK(clk), .RST(rst), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_FRAME_END(rx_frame_end), .TX_READY(tx_ready),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .GRIP_CMD(grip_cmd),
    .ACT_STATE(act_state)
  );

  gmr_master_model #(.GAP_CYCLES(20)) gmr_master_model_i (
    .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_frame_end(rx_frame_end), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid)
  );

  // ==========================================================
  // Helpers
  // Own check value: reflected, init all ones
  function automatic logic [15:0] crc16(input logic [7:0] q [$]);
    logic [15:0] c;
    c = `GMR_CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ `GMR_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Build the frame, append the check value low byte first
  task automatic send_req(input logic [127:0] req, input int rn,
                          input logic bad);
    logic [7:0] q [$];
    logic [15:0] c;
    for (int i = 0; i < rn; i++)
      q.push_back(req[8*(rn-1-i) +: 8]); // Field order
    c = crc16(q) ^ {15'h0, bad};
    q.push_back(c[7:0]); // Check value closes the frame
    q.push_back(c[15:8]);
    gmr_master_model_i.out_q = q;
    gmr_master_model_i.got.delete();
    gmr_master_model_i.send();
  endtask

  // Bounded wait; a short one where silence is due
  task automatic wait_resp(input int n);
    int lim;
    lim = (n > 0) ? 400 : 30;
    repeat (lim)
    begin
      if (n > 0 && gmr_master_model_i.got.size() >= n)
        break;
      @(posedge clk);
    end
  endtask

  task automatic run_row(input int i);
    logic [7:0] e [$];
    logic [15:0] c;
    for (int k = 0; k < rows[i].sn; k++)
      e.push_back(rows[i].rsp[8*(rows[i].sn-1-k) +: 8]);
    c = crc16(e);
    if (rows[i].sn > 0)
    begin
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    send_req(rows[i].req, rows[i].rn, rows[i].bad);
    wait_resp(e.size());
    check(48'(gmr_master_model_i.got.size()), 48'(e.size()));
    foreach (e[k])
      check(48'(gmr_master_model_i.got[k]), 48'(e[k]));
    check(grip_cmd, rows[i].cmd);
    check(48'(act_state), 48'(rows[i].st));
  endtask

  task automatic reset_check();
    check(grip_cmd, 48'h0); // Reset values
    check(48'({act_state, tx_valid, tx_data}), 48'h0);
  endtask

  // ==========================================================
  // Clock and watchdog of 20000 cycles, about six times the run
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #100000;
    mismatches++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'h1;
    mismatches = 0;
    n_checks = 0;
    rows = '{
      '{128'h091003E8000306000000000000, 13, 80'h091003E80003, 6, 1'h0,
        48'h0, 2'h0}, // Clear activate first
      '{128'h091003E8000306010000000000, 13, 80'h091003E80003, 6, 1'h0,
        48'h010000000000, 2'h1}, // Then set it
      '{128'h090307D00001, 6, 80'h0903021100, 5, 1'h0,
        48'h010000000000, 2'h1}, // In progress
      '{128'h090307D00001, 6, 80'h0903023100, 5, 1'h0,
        48'h010000000000, 2'h3}, // Finished
      '{128'h091003E8000306090000FFFFFF, 13, 80'h091003E80003, 6, 1'h0,
        48'h090000FFFFFF, 2'h3}, // Full close
      '{128'h090307D00003, 6, 80'h090306390000000000, 9, 1'h0,
        48'h090000FFFFFF, 2'h3}, // Three words
      '{128'h091003E900020460E63CC8, 11, 80'h091003E90002, 6, 1'h0,
        48'h090060E63CC8, 2'h3}, // Offset start
      '{128'h091003E80001020000, 9, 80'h0, 0, 1'h1,
        48'h090060E63CC8, 2'h3}, // Bad check value
      '{128'h0A1003E80001020000, 9, 80'h0, 0, 1'h0,
        48'h090060E63CC8, 2'h3}, // Foreign identifier
      '{128'h091003E80001040000, 9, 80'h0, 0, 1'h0,
        48'h090060E63CC8, 2'h3}, // Wrong byte count
      '{128'h091003EA0001021234, 9, 80'h091003EA0001, 6, 1'h0,
        48'h090060E61234, 2'h3}, // Last register alone
      '{128'h091003E80001020000, 9, 80'h091003E80001, 6, 1'h0,
        48'h000060E61234, 2'h0}, // Activate cleared
      '{128'h090303E80003, 6, 80'h090306000060E61234, 9, 1'h0,
        48'h000060E61234, 2'h0}, // Command words read back
      '{128'h090407D00001, 6, 80'h0, 0, 1'h0,
        48'h000060E61234, 2'h0}, // Unsupported code
      '{128'h091003EA00020411112222, 11, 80'h0, 0, 1'h0,
        48'h000060E61234, 2'h0}, // Write past the map
      '{128'h091003E8000306AAAABBBBCCCC000000, 16, 80'h0, 0, 1'h0,
        48'h000060E61234, 2'h0}, // Frame too long
      '{128'h090307D00001, 6, 80'h0903020000, 5, 1'h0,
        48'h0, 2'h0} // After a second reset
    };
    repeat (8) @(posedge clk);
    reset_check();
    #1;
    rst = 1'h0;
    for (int i = 0; i < 3; i++)
      run_row(i);
    // Slow sender from here on; poll until activation completes
    gmr_master_model_i.stall = 3;
    for (int k = 0; k < 100; k++)
    begin
      send_req(128'h090307D00001, 6, 1'h0); // Status poll
      wait_resp(7);
      if (gmr_master_model_i.got[3] === 8'h31)
        break;
    end
    for (int i = 3; i < 16; i++)
      run_row(i);
    // Reset in mid-run clears the command words and the state
    @(posedge clk);
    #1;
    rst = 1'h1;
    @(posedge clk);
    #1;
    reset_check();
    rst = 1'h0;
    run_row(16);
    finish_test();
  end
endmodule // gmr_modbus_slave_tb_top
